// ==== tif_pkg.sv ====
// Constants for the timer interrupt flag and prescaler sync block
package tif_pkg;
   // Register offsets
   localparam logic [7:0] TIF_ADDR_EVENT_FLAGS = 8'h16;
   localparam logic [7:0] TIF_ADDR_SYNC_CTRL   = 8'h23;
   localparam logic [7:0] TIF_ADDR_IRQ_MASK    = 8'h6f;
   // Bit positions shared by flag and mask registers
   localparam int TIF_BIT_OVERFLOW = 0;
   localparam int TIF_BIT_CMP_A    = 1;
   localparam int TIF_BIT_CMP_B    = 2;
   localparam int TIF_BIT_CAPTURE  = 5;
   // Sync control bit positions
   localparam int TIF_BIT_SHARED_PSR = 0;
   localparam int TIF_BIT_SYNC_HOLD  = 7;
   // Implemented bits and reset values
   localparam logic [7:0] TIF_FLAG_MASK   = 8'h27;
   localparam logic [7:0] TIF_FLAG_RESET  = 8'h00;
   localparam logic [7:0] TIF_MASK_RESET  = 8'h00;
   localparam logic [7:0] TIF_SYNC_RESET  = 8'h00;
   // Waveform modes using the capture register as top
   localparam logic [3:0] TIF_WGM_PWM_CAP_TOP = 4'h8;
   localparam logic [3:0] TIF_WGM_CTC_CAP_TOP = 4'hc;
   localparam logic [3:0] TIF_WGM_FPWM_CAP_TOP = 4'he;
   localparam logic [3:0] TIF_WGM_PFC_CAP_TOP = 4'ha;
   // Interrupt source index
   localparam int TIF_SRC_OVERFLOW = 0;
   localparam int TIF_SRC_CMP_A    = 1;
   localparam int TIF_SRC_CMP_B    = 2;
   localparam int TIF_SRC_CAPTURE  = 3;
   localparam int TIF_NUM_SRC      = 4;
endpackage

// ==== tif_timer_irq.sv ====
// Timer event flags, interrupt requests and shared prescaler reset control
//
// Contract
// - Compare-A request needs enable, global flag, flag.
// - Overflow request needs enable, global flag, flag.
// - Capture bit5, compare-B bit2 gated, global qualified.
// - Flags at bits 5,2,1,0; rest read zero.
// - Capture pin event sets capture flag outside capture-top modes.
// - Capture-top mode: top reached sets capture flag.
// - Capture flag cleared by vector or one-write.
// - Compare-B flag set tick after match.
// - Forced compare-B strobe leaves flag alone.
// - Compare-B flag cleared by vector or one-write.
// - Compare-A flag set tick after match.
// - Forced compare-A strobe leaves flag alone.
// - Compare-A flag cleared by vector or one-write.
// - Overflow flag set on counter overflow.
// - Overflow flag cleared by vector or one-write.
// - Sync hold keeps prescaler reset bits asserted.
// - Clearing sync hold clears prescaler resets together.
// - Prescaler reset self-clears unless sync hold.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module tif_timer_irq
   import tif_pkg::*;
(
   // Clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         rstn,
   // Register port
   input  wire logic [7:0]                   regAddr,
   input  wire logic [7:0]                   regWdata,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output logic      [7:0]                   regRdata,
   // Counter datapath events, same clock
   input  wire logic                         timerTick,
   input  wire logic                         cmpAMatch,
   input  wire logic                         cmpBMatch,
   input  wire logic                         overflowEvent,
   input  wire logic                         topReached,
   input  wire logic [3:0]                   waveformModeSel,
   // Capture pin, asynchronous
   input  wire logic                         captureInputPin,
   // Core interrupt logic
   input  wire logic                         globalIrqEnable,
   input  wire logic [tif_pkg::TIF_NUM_SRC-1:0] irqAck,
   output logic      [tif_pkg::TIF_NUM_SRC-1:0] irqRequest,
   // Prescaler control
   output logic                              sharedPrescalerReset
);
   import tif_pkg::*;

   // Capture pin synchroniser and edge detect
   logic capSync1;
   logic capSync2;
   logic capPrev;
   logic next_capSync1;
   logic next_capSync2;
   logic next_capPrev;

   always_comb begin
      next_capSync1 = captureInputPin;
      next_capSync2 = capSync1;
      next_capPrev  = capSync2;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         capSync1 <= 1'b0;
         capSync2 <= 1'b0;
         capPrev  <= 1'b0;
      end else begin
         capSync1 <= next_capSync1;
         capSync2 <= next_capSync2;
         capPrev  <= next_capPrev;
      end
   end

   function automatic logic capIsTop(input logic [3:0] mode);
      capIsTop = (mode == TIF_WGM_PWM_CAP_TOP) || (mode == TIF_WGM_PFC_CAP_TOP) ||
                 (mode == TIF_WGM_CTC_CAP_TOP) || (mode == TIF_WGM_FPWM_CAP_TOP);
   endfunction

   logic capPinEdge;
   logic captureSet;
   assign capPinEdge = capSync2 & ~capPrev;
   // Pin events are ignored while the capture register defines top
   assign captureSet = capIsTop(waveformModeSel) ? (topReached & timerTick)
                                                 : capPinEdge;

   // Compare matches are seen on one timer tick and flagged on the next
   logic matchPendA;
   logic matchPendB;
   logic next_matchPendA;
   logic next_matchPendB;

   always_comb begin
      next_matchPendA = matchPendA;
      next_matchPendB = matchPendB;
      if (timerTick) begin
         next_matchPendA = cmpAMatch;
         next_matchPendB = cmpBMatch;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         matchPendA <= 1'b0;
         matchPendB <= 1'b0;
      end else begin
         matchPendA <= next_matchPendA;
         matchPendB <= next_matchPendB;
      end
   end

   // Forced compare strobes never reach this block, so they set nothing
   logic cmpASet;
   logic cmpBSet;
   assign cmpASet = timerTick & matchPendA;
   assign cmpBSet = timerTick & matchPendB;

   // Flags, mask and sync control registers
   logic [7:0] eventFlags;
   logic [7:0] irqMask;
   logic       syncHold;
   logic       sharedPsr;
   logic [7:0] next_eventFlags;
   logic [7:0] next_irqMask;
   logic       next_syncHold;
   logic       next_sharedPsr;
   logic [7:0] setVec;
   logic [7:0] clrVec;
   logic       wrFlags;
   logic       wrSync;

   assign wrFlags = regWrite && (regAddr == TIF_ADDR_EVENT_FLAGS);
   assign wrSync  = regWrite && (regAddr == TIF_ADDR_SYNC_CTRL);

   always_comb begin
      setVec = 8'h00;
      setVec[TIF_BIT_CAPTURE]  = captureSet;
      setVec[TIF_BIT_CMP_B]    = cmpBSet;
      setVec[TIF_BIT_CMP_A]    = cmpASet;
      setVec[TIF_BIT_OVERFLOW] = overflowEvent;
      clrVec = wrFlags ? regWdata : 8'h00;
      clrVec[TIF_BIT_CAPTURE]  = clrVec[TIF_BIT_CAPTURE]  | irqAck[TIF_SRC_CAPTURE];
      clrVec[TIF_BIT_CMP_B]    = clrVec[TIF_BIT_CMP_B]    | irqAck[TIF_SRC_CMP_B];
      clrVec[TIF_BIT_CMP_A]    = clrVec[TIF_BIT_CMP_A]    | irqAck[TIF_SRC_CMP_A];
      clrVec[TIF_BIT_OVERFLOW] = clrVec[TIF_BIT_OVERFLOW] | irqAck[TIF_SRC_OVERFLOW];
      // Set wins so an event in the clearing cycle is kept
      next_eventFlags = ((eventFlags & ~clrVec) | setVec) & TIF_FLAG_MASK;
      next_irqMask = irqMask;
      if (regWrite && (regAddr == TIF_ADDR_IRQ_MASK)) begin
         next_irqMask = regWdata & TIF_FLAG_MASK;
      end
      next_syncHold  = syncHold;
      next_sharedPsr = sharedPsr;
      if (wrSync) begin
         next_syncHold  = regWdata[TIF_BIT_SYNC_HOLD];
         next_sharedPsr = regWdata[TIF_BIT_SHARED_PSR];
         if (!regWdata[TIF_BIT_SYNC_HOLD]) begin
            // One reset cycle if not held; releasing a hold ends it at once, then all timers run together
            next_sharedPsr = regWdata[TIF_BIT_SHARED_PSR] & ~syncHold;
         end
      end else if (!syncHold) begin
         next_sharedPsr = 1'b0;
      end                         // else held
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         eventFlags <= TIF_FLAG_RESET;
         irqMask    <= TIF_MASK_RESET;
         syncHold   <= TIF_SYNC_RESET[TIF_BIT_SYNC_HOLD];
         sharedPsr  <= TIF_SYNC_RESET[TIF_BIT_SHARED_PSR];
      end else begin
         eventFlags <= next_eventFlags;
         irqMask    <= next_irqMask;
         syncHold   <= next_syncHold;
         sharedPsr  <= next_sharedPsr;
      end
   end

   assign sharedPrescalerReset = sharedPsr;

   // Interrupt requests, registered from the next flag and mask values
   logic [TIF_NUM_SRC-1:0] next_irqRequest;
   logic [TIF_NUM_SRC-1:0] gatedVec;

   always_comb begin
      gatedVec = '0;
      gatedVec[TIF_SRC_OVERFLOW] = next_eventFlags[TIF_BIT_OVERFLOW]
                                   & next_irqMask[TIF_BIT_OVERFLOW];
      gatedVec[TIF_SRC_CMP_A]    = next_eventFlags[TIF_BIT_CMP_A]
                                   & next_irqMask[TIF_BIT_CMP_A];
      gatedVec[TIF_SRC_CMP_B]    = next_eventFlags[TIF_BIT_CMP_B]
                                   & next_irqMask[TIF_BIT_CMP_B];
      gatedVec[TIF_SRC_CAPTURE]  = next_eventFlags[TIF_BIT_CAPTURE]
                                   & next_irqMask[TIF_BIT_CAPTURE];
      next_irqRequest = globalIrqEnable ? gatedVec : '0;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irqRequest <= '0;
      end else begin
         irqRequest <= next_irqRequest;
      end
   end

   // Read port, data one cycle after the strobe
   logic [7:0] next_regRdata;

   always_comb begin
      next_regRdata = 8'h00;
      if (regRead) begin
         case (regAddr)
            TIF_ADDR_EVENT_FLAGS: next_regRdata = eventFlags & TIF_FLAG_MASK;
            TIF_ADDR_IRQ_MASK:    next_regRdata = irqMask;
            TIF_ADDR_SYNC_CTRL: begin
               next_regRdata[TIF_BIT_SYNC_HOLD]  = syncHold;
               next_regRdata[TIF_BIT_SHARED_PSR] = sharedPsr;
            end
            default:              next_regRdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= next_regRdata;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_cmpa_req;
      irqRequest[TIF_SRC_CMP_A] |-> $past(globalIrqEnable) && eventFlags[TIF_BIT_CMP_A]
                                    && irqMask[TIF_BIT_CMP_A];
   endproperty
   a_cmpa_req: assert property (p_cmpa_req) else $error("Compare-A request without cause");

   property p_ovf_req;
      irqRequest[TIF_SRC_OVERFLOW] |-> $past(globalIrqEnable) && eventFlags[TIF_BIT_OVERFLOW]
                                       && irqMask[TIF_BIT_OVERFLOW];
   endproperty
   a_ovf_req: assert property (p_ovf_req) else $error("Overflow request without cause");

   property p_capb_req;
      (eventFlags[TIF_BIT_CAPTURE] && irqMask[TIF_BIT_CAPTURE] && $past(globalIrqEnable))
         == irqRequest[TIF_SRC_CAPTURE];
   endproperty
   a_capb_req: assert property (p_capb_req) else $error("Capture request mismatch");

   property p_reserved_zero;
      (eventFlags & ~TIF_FLAG_MASK) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved flag set");

   property p_cap_pin;
      (!capIsTop(waveformModeSel) && capPinEdge) |=> eventFlags[TIF_BIT_CAPTURE];
   endproperty
   a_cap_pin: assert property (p_cap_pin) else $error("Capture edge lost");

   property p_cmpb_tick;
      (timerTick && matchPendB) |=> eventFlags[TIF_BIT_CMP_B];
   endproperty
   a_cmpb_tick: assert property (p_cmpb_tick) else $error("Compare-B flag not set");

   property p_cmpa_next;
      (timerTick && matchPendA) |=> eventFlags[TIF_BIT_CMP_A];
   endproperty
   a_cmpa_next: assert property (p_cmpa_next) else $error("Compare-A flag not set");

   property p_cmpa_no_early;
      (!eventFlags[TIF_BIT_CMP_A] && !timerTick) |=> !eventFlags[TIF_BIT_CMP_A];
   endproperty
   a_cmpa_no_early: assert property (p_cmpa_no_early) else $error("Compare-A set off tick");

   property p_ack_clear;
      (irqAck[TIF_SRC_CMP_B] && !cmpBSet && !wrFlags) |=> !eventFlags[TIF_BIT_CMP_B];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("Compare-B ack did not clear");

   property p_ack_only_own;
      (irqAck == 4'h1 && !wrFlags && eventFlags[TIF_BIT_CMP_A]) |=> eventFlags[TIF_BIT_CMP_A];
   endproperty
   a_ack_only_own: assert property (p_ack_only_own) else $error("Foreign flag cleared");

   property p_set_wins;
      (overflowEvent && irqAck[TIF_SRC_OVERFLOW]) |=> eventFlags[TIF_BIT_OVERFLOW];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Set lost to clear");

   property p_cmpb_no_early;
      (!eventFlags[TIF_BIT_CMP_B] && !timerTick) |=> !eventFlags[TIF_BIT_CMP_B];
   endproperty
   a_cmpb_no_early: assert property (p_cmpb_no_early) else $error("Compare-B set off tick");

   property p_psr_selfclear;
      (!syncHold && sharedPsr && !wrSync) |=> !sharedPsr;
   endproperty
   a_psr_selfclear: assert property (p_psr_selfclear) else $error("Prescaler reset stuck");

   property p_sync_release;
      (syncHold && wrSync && !regWdata[TIF_BIT_SYNC_HOLD]) |=> !sharedPsr && !syncHold;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("Sync release failed");

   property p_hold_keep;
      (syncHold && sharedPsr && !wrSync) |=> sharedPsr;
   endproperty
   a_hold_keep: assert property (p_hold_keep) else $error("Held prescaler reset dropped");

   property p_psr_set;
      (wrSync && regWdata[TIF_BIT_SHARED_PSR] && !syncHold) |=> sharedPsr;
   endproperty
   a_psr_set: assert property (p_psr_set) else $error("Prescaler reset not raised");

   property p_cmpb_req;
      irqRequest[TIF_SRC_CMP_B] |-> $past(globalIrqEnable) && eventFlags[TIF_BIT_CMP_B]
                                    && irqMask[TIF_BIT_CMP_B];
   endproperty
   a_cmpb_req: assert property (p_cmpb_req) else $error("Compare-B request without cause");

   property p_cap_top;
      (capIsTop(waveformModeSel) && topReached && timerTick) |=> eventFlags[TIF_BIT_CAPTURE];
   endproperty
   a_cap_top: assert property (p_cap_top) else $error("Capture top flag lost");

   // Clears are checked only when no set lands in the same cycle
   property p_cap_ack;
      (irqAck[TIF_SRC_CAPTURE] && !captureSet) |=> !eventFlags[TIF_BIT_CAPTURE];
   endproperty
   a_cap_ack: assert property (p_cap_ack) else $error("Capture ack did not clear");

   property p_ovf_ack;
      (irqAck[TIF_SRC_OVERFLOW] && !overflowEvent) |=> !eventFlags[TIF_BIT_OVERFLOW];
   endproperty
   a_ovf_ack: assert property (p_ovf_ack) else $error("Overflow ack did not clear");

   property p_cmpa_ack;
      (irqAck[TIF_SRC_CMP_A] && !cmpASet) |=> !eventFlags[TIF_BIT_CMP_A];
   endproperty
   a_cmpa_ack: assert property (p_cmpa_ack) else $error("Compare-A ack did not clear");

   property p_wr_clear;
      (wrFlags && regWdata[TIF_BIT_CMP_B] && !cmpBSet) |=> !eventFlags[TIF_BIT_CMP_B];
   endproperty
   a_wr_clear: assert property (p_wr_clear) else $error("Write one did not clear");

   property p_ovf_set;
      overflowEvent |=> eventFlags[TIF_BIT_OVERFLOW];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set");

   property p_rdata_idle;
      !$past(regRead) |-> regRdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside slot");

   // Main scenarios
   c_cmpa_ack: cover property (irqAck[TIF_SRC_CMP_A]);
   c_hold: cover property (syncHold && sharedPsr);
   c_ovf_irq: cover property (irqRequest[TIF_SRC_OVERFLOW]);
   c_sync_release: cover property (syncHold && sharedPsr ##1 !syncHold);
   c_cap_top: cover property (capIsTop(waveformModeSel) && captureSet);
endmodule // tif_timer_irq

// ==== tif_core_model.sv ====
// Core-side model that acknowledges pending timer interrupt requests
`timescale 1ns/1ns
module tif_core_model
   import tif_pkg::*;
(
   // Clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            rstn,
   // Requests in, vector acknowledges out
   input  wire logic                            ackEnable,
   input  wire logic [tif_pkg::TIF_NUM_SRC-1:0] irqRequest,
   output logic      [tif_pkg::TIF_NUM_SRC-1:0] irqAck
);
   import tif_pkg::*;

   logic [2:0] holdOff;

   // One vector at a time, lowest index first; hold off for four cycles after each acknowledge
   always_ff @(posedge clk_sys) begin
      irqAck <= '0;
      if (!rstn) begin
         holdOff <= 3'h0;
      end else if (holdOff != 3'h0) begin
         holdOff <= holdOff - 3'h1;
      end else if (ackEnable && (irqRequest != '0)) begin
         irqAck  <= irqRequest & (~irqRequest + 4'h1);
         holdOff <= 3'h4;
      end
   end
endmodule // tif_core_model

// ==== timer_irq_flags_prescaler_sync_test.sv ====
// Self-checking bench for the timer flag and prescaler sync block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module timer_irq_flags_prescaler_sync_test;
   import tif_pkg::*;
   logic       clk_sys, rstn, regWrite, regRead, timerTick, cmpAMatch, cmpBMatch;
   logic       overflowEvent, topReached, captureInputPin, globalIrqEnable, ackEnable;
   logic       sharedPrescalerReset;
   logic [7:0] regAddr, regWdata, regRdata, rdVal, rnd;
   logic [3:0] waveformModeSel, irqAck, irqRequest;
   logic [7:0] bitTab [4] = '{8'h01, 8'h02, 8'h04, 8'h20};
   logic [3:0] modeTab [4] = '{TIF_WGM_PWM_CAP_TOP, TIF_WGM_PFC_CAP_TOP,
                               TIF_WGM_CTC_CAP_TOP, TIF_WGM_FPWM_CAP_TOP};
   int         miscompares = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         hiCnt;

   tif_timer_irq DUT (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .timerTick(timerTick),
      .cmpAMatch(cmpAMatch), .cmpBMatch(cmpBMatch), .overflowEvent(overflowEvent),
      .topReached(topReached), .waveformModeSel(waveformModeSel),
      .captureInputPin(captureInputPin), .globalIrqEnable(globalIrqEnable), .irqAck(irqAck),
      .irqRequest(irqRequest), .sharedPrescalerReset(sharedPrescalerReset));
   tif_core_model core (.clk_sys(clk_sys), .rstn(rstn), .ackEnable(ackEnable),
      .irqRequest(irqRequest), .irqAck(irqAck));

   function automatic logic [3:0] reqExp(logic [7:0] f, logic [7:0] m, logic g);
      return {f[5] & m[5], f[2] & m[2], f[1] & m[1], f[0] & m[0]} & {4{g}};
   endfunction

   task automatic final_report();
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys); regAddr <= a; regWdata <= d; regWrite <= 1'b1;
      @(posedge clk_sys); regWrite <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys); regAddr <= a; regRead <= 1'b1;
      @(posedge clk_sys); regRead <= 1'b0;
      #1 rdVal = regRdata;
   endtask
   task automatic tick(logic a, logic b, logic top);
      @(posedge clk_sys); timerTick <= 1'b1; cmpAMatch <= a; cmpBMatch <= b; topReached <= top;
      @(posedge clk_sys); timerTick <= 1'b0; cmpAMatch <= 1'b0; cmpBMatch <= 1'b0;
      topReached <= 1'b0;
   endtask
   task automatic ovf();
      @(posedge clk_sys); overflowEvent <= 1'b1;
      @(posedge clk_sys); overflowEvent <= 1'b0;
   endtask
   task automatic pinRise();
      @(posedge clk_sys); captureInputPin <= 1'b0;
      idle(5); captureInputPin <= 1'b1;
      idle(6);
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end

   initial begin
      {rstn, regWrite, regRead, timerTick, cmpAMatch, cmpBMatch} = '0;
      {overflowEvent, topReached, captureInputPin, globalIrqEnable, ackEnable} = '0;
      {regAddr, regWdata, waveformModeSel} = '0;
      rnd = 8'($urandom(66855));
      idle(10);
      rstn <= 1'b1;
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("flags reset", TIF_FLAG_RESET, rdVal)
      rd(TIF_ADDR_SYNC_CTRL); `CHK("sync reset", TIF_SYNC_RESET, rdVal)
      rd(TIF_ADDR_IRQ_MASK); `CHK("mask reset", TIF_MASK_RESET, rdVal)
      rd(8'h40); `CHK("unmapped", 8'h00, rdVal)
      repeat (8) begin
         rnd = 8'($urandom());
         wr(TIF_ADDR_IRQ_MASK, rnd); wr(TIF_ADDR_EVENT_FLAGS, rnd);
         rd(TIF_ADDR_IRQ_MASK); `CHK("mask rw", rnd & TIF_FLAG_MASK, rdVal)
         rd(TIF_ADDR_EVENT_FLAGS); `CHK("flags idle", 8'h00, rdVal)
      end
      wr(TIF_ADDR_IRQ_MASK, 8'h00);
      for (int i = 0; i < 2; i++) begin
         tick(i == 0, i == 1, 1'b0); idle(1);
         rd(TIF_ADDR_EVENT_FLAGS); `CHK("cmp early", 8'h00, rdVal)
         tick(1'b0, 1'b0, 1'b0); idle(1);
         rd(TIF_ADDR_EVENT_FLAGS); `CHK("cmp set", 8'h02 << i, rdVal)
         wr(TIF_ADDR_EVENT_FLAGS, 8'h02 << i);
         rd(TIF_ADDR_EVENT_FLAGS); `CHK("cmp clear", 8'h00, rdVal)
      end
      ovf(); idle(1);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("ovf set", 8'h01, rdVal)
      @(posedge clk_sys); overflowEvent <= 1'b1; regWrite <= 1'b1;
      regAddr <= TIF_ADDR_EVENT_FLAGS; regWdata <= 8'h01;
      @(posedge clk_sys); overflowEvent <= 1'b0; regWrite <= 1'b0;
      idle(1);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("set wins", 8'h01, rdVal)
      wr(TIF_ADDR_EVENT_FLAGS, 8'h01);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("ovf clear", 8'h00, rdVal)
      pinRise();
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("pin capture", 8'h20, rdVal)
      wr(TIF_ADDR_EVENT_FLAGS, 8'h20);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("cap clear", 8'h00, rdVal)
      for (int i = 0; i < 4; i++) begin
         waveformModeSel <= modeTab[i];
         tick(1'b0, 1'b0, 1'b1); idle(1);
         rd(TIF_ADDR_EVENT_FLAGS); `CHK("top capture", 8'h20, rdVal)
         wr(TIF_ADDR_EVENT_FLAGS, 8'h20);
      end
      waveformModeSel <= 4'h0;
      // All four flags pending, then sweep enables against the global flag
      tick(1'b1, 1'b1, 1'b0); tick(1'b0, 1'b0, 1'b0); ovf(); pinRise();
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("all flags", 8'h27, rdVal)
      for (int j = 0; j < 8; j++) begin
         wr(TIF_ADDR_IRQ_MASK, bitTab[j / 2]); globalIrqEnable <= j[0];
         idle(3); #1;
         `CHK("irq gate", reqExp(8'h27, bitTab[j / 2], j[0]), irqRequest)
      end
      wr(TIF_ADDR_IRQ_MASK, 8'h06); ackEnable <= 1'b1;
      idle(16);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("ack own flag", 8'h21, rdVal)
      ackEnable <= 1'b0;
      wr(TIF_ADDR_IRQ_MASK, 8'h00); wr(TIF_ADDR_EVENT_FLAGS, 8'h21);
      rd(TIF_ADDR_EVENT_FLAGS); `CHK("flags empty", 8'h00, rdVal)
      wr(TIF_ADDR_SYNC_CTRL, 8'h01);
      hiCnt = 0;
      repeat (6) begin
         #1 hiCnt += int'(sharedPrescalerReset);
         @(posedge clk_sys);
      end
      `CHK("psr pulse", 1, hiCnt)
      rd(TIF_ADDR_SYNC_CTRL); `CHK("psr self clear", 8'h00, rdVal)
      wr(TIF_ADDR_SYNC_CTRL, 8'h81); idle(4); #1;
      `CHK("psr held", 1'b1, sharedPrescalerReset)
      rd(TIF_ADDR_SYNC_CTRL); `CHK("sync held", 8'h81, rdVal)
      wr(TIF_ADDR_SYNC_CTRL, 8'h01); idle(2); #1;
      `CHK("psr released", 1'b0, sharedPrescalerReset)
      rd(TIF_ADDR_SYNC_CTRL); `CHK("sync released", 8'h00, rdVal)
      final_report();
   end
endmodule // timer_irq_flags_prescaler_sync_test
